// [aec_consts.vh]
// Purpose: Shared constants of the dual event counter block
// Assumes: Included by its bare name from every design file
// Notes:   Byte addresses of the AXI4-Lite register map, fields and reset values
`ifndef AEC_CONSTS_VH
`define AEC_CONSTS_VH

// Register byte addresses
`define AEC_ADDR_CTRL_STATUS  4'h0
`define AEC_ADDR_COUNT_HIGH   4'h4
`define AEC_ADDR_COUNT_LOW    4'h8
`define AEC_ADDR_CONFIG       4'hC
`define AEC_ADDR_W            4

// Control/status register fields
`define AEC_CS_UPPER_OVF      7
`define AEC_CS_LOWER_OVF      6
`define AEC_CS_RESERVED       5
`define AEC_CS_SPLIT          4
`define AEC_CS_UPPER_EN       3
`define AEC_CS_LOWER_EN       2
`define AEC_CS_UPPER_REL      1
`define AEC_CS_LOWER_REL      0
`define AEC_CS_RESET          8'h00

// Configuration register fields
`define AEC_CFG_UPPER_CLK_HI  7
`define AEC_CFG_UPPER_CLK_LO  6
`define AEC_CFG_LOWER_CLK_HI  5
`define AEC_CFG_LOWER_CLK_LO  4
`define AEC_CFG_UPPER_EDGE_HI 3
`define AEC_CFG_UPPER_EDGE_LO 2
`define AEC_CFG_LOWER_EDGE_HI 1
`define AEC_CFG_LOWER_EDGE_LO 0
`define AEC_CFG_PWM_GATE_EN   8
`define AEC_CFG_IRQ_FLAG      9
`define AEC_CFG_IRQ_EN        10
`define AEC_CFG_RESET         11'h000
`define AEC_CFG_W             11

// Clock select codes
`define AEC_CLK_PIN           2'h0
`define AEC_CLK_DIV2          2'h1
`define AEC_CLK_DIV4          2'h2
`define AEC_CLK_DIV8          2'h3

// Edge select codes
`define AEC_EDGE_FALL         2'h0
`define AEC_EDGE_RISE         2'h1
`define AEC_EDGE_BOTH         2'h2

// Counter limits
`define AEC_COUNT_MAX         8'hFF
`define AEC_COUNT_ZERO        8'h00

// AXI responses
`define AEC_RESP_OKAY         2'h0
`define AEC_RESP_SLVERR       2'h2

`endif

// [aec_event_counter.v]
// Purpose: Dual 8-bit event counter, chainable to 16 bits, AXI4-Lite registers
// Assumes: Pins synchronous to ref_clk; 100 MHz clock; one write, one read at a time
// Notes:   Function
// Function
// [RULE_01] Upper rollover sets upper overflow flag
// [RULE_02] Lower rollover sets lower flag, split only
// [RULE_03] Flag clears by zero write after reading one
// [RULE_04] Writing one to flags does nothing
// [RULE_05] Split zero chains halves into 16 bits
// [RULE_06] Split one runs two 8-bit counters
// [RULE_07] Upper enable zero blocks and holds count
// [RULE_08] Lower enable zero blocks and holds count
// [RULE_09] Upper release zero holds upper cleared
// [RULE_10] Lower release zero holds lower cleared
// [RULE_11] Upper counter read-only, high byte
// [RULE_12] Lower counter read-only, low byte
// [RULE_13] Upper source: pin, divided clocks, lower carry
// [RULE_14] Lower source: pin or divided clocks
// [RULE_15] Software writes zero to reserved bit
// [RULE_16] Selected gate high lets counts pass
// [RULE_17] 16-bit count wraps all ones to zero
// [RULE_18] Overflow sets irq flag, enable raises request
// [RULE_19] Lower select 00 means pin, reset default
// [RULE_20] Overflow beats simultaneous clearing write
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "aec_consts.vh"

module aec_event_counter (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        reset_n,
	// AXI4-Lite write address
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_awaddr,
	// AXI4-Lite write data
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	output reg  [1:0]  s_axi_bresp,
	// AXI4-Lite read address
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	input  wire [31:0] s_axi_araddr,
	// AXI4-Lite read data
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	// Event pins and count gates
	input  wire        upperEventPin,
	input  wire        lowerEventPin,
	input  wire        externalCountGate,
	input  wire        pwmCountGate,
	// Interrupt request to the CPU
	output reg         overflowIrq_r
);

	// Register state
	reg  [7:0]              ctrlStatus_r;
	reg  [`AEC_CFG_W-1:0]   config_r;
	reg  [7:0]              upperCount_r;
	reg  [7:0]              lowerCount_r;
	reg                     upperClearArmed_r;
	reg                     lowerClearArmed_r;

	// Bus holding state
	reg                     awHeld_r;
	reg                     wHeld_r;
	reg  [`AEC_ADDR_W-1:0]  awAddr_r;
	reg  [31:0]             wData_r;
	reg  [3:0]              wStrb_r;

	// Source ticks
	wire                    tickDiv2;
	wire                    tickDiv4;
	wire                    tickDiv8;
	wire [1:0]              srcTick;

	// Count control
	wire                    splitMode;
	wire                    countGate;
	wire                    lowerTick;
	wire                    lowerCarry;
	wire                    upperTick;
	wire                    upperWrap;
	wire                    upperOvfSet;
	wire                    lowerOvfSet;
	wire                    anyOverflow;

	// Bus decode
	wire                    writeFire;
	wire                    readFire;
	wire [`AEC_ADDR_W-1:0]  readAddr;
	wire                    wrCtrl;
	wire                    wrConfig;
	wire                    wrMapped;
	wire                    rdCtrl;
	reg  [31:0]             readData;
	reg                     readHit;

	// Next values
	reg  [7:0]              ctrlStatus_nxt;
	reg  [`AEC_CFG_W-1:0]   config_nxt;
	reg  [7:0]              upperCount_nxt;
	reg  [7:0]              lowerCount_nxt;
	reg                     upperClearArmed_nxt;
	reg                     lowerClearArmed_nxt;

	genvar gi;

	// Divided system clock ticks
	aec_prescaler u_prescaler (
		.ref_clk    (ref_clk),
		.reset_n    (reset_n),
		.tickDiv2_r (tickDiv2),
		.tickDiv4_r (tickDiv4),
		.tickDiv8_r (tickDiv8)
	);

	// One source selector per half: index 1 upper, index 0 lower
	// [RULE_14] lower source choice
	// [RULE_19] code 00 picks the pin
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_src
			aec_source_select u_src (
				.ref_clk    (ref_clk),
				.reset_n    (reset_n),
				.eventPin   (gi == 1 ? upperEventPin : lowerEventPin),
				.edgeSel    (config_r[2*gi+1 -: 2]),
				.clockSel   (config_r[2*gi+5 -: 2]),
				.tickDiv2   (tickDiv2),
				.tickDiv4   (tickDiv4),
				.tickDiv8   (tickDiv8),
				.sourceTick (srcTick[gi])
			);
		end
	endgenerate

	assign splitMode = ctrlStatus_r[`AEC_CS_SPLIT];

	// [RULE_16] gate selection
	assign countGate = config_r[`AEC_CFG_PWM_GATE_EN] ? pwmCountGate : externalCountGate;

	// [RULE_08] lower enable gating
	assign lowerTick  = countGate & ctrlStatus_r[`AEC_CS_LOWER_EN] & srcTick[0]
		& ctrlStatus_r[`AEC_CS_LOWER_REL];
	assign lowerCarry = lowerTick & (lowerCount_r == `AEC_COUNT_MAX);

	// [RULE_05] chain through lower carry
	// [RULE_06] independent upper source
	// [RULE_13] upper source choice
	// [RULE_07] upper enable gating
	assign upperTick = ctrlStatus_r[`AEC_CS_UPPER_EN] & ctrlStatus_r[`AEC_CS_UPPER_REL]
		& (splitMode ? (countGate & srcTick[1]) : lowerCarry);
	assign upperWrap = upperTick & (upperCount_r == `AEC_COUNT_MAX);

	// [RULE_01] upper rollover flag
	// [RULE_17] 16-bit wrap flag
	assign upperOvfSet = upperWrap;
	// [RULE_02] lower flag only split
	assign lowerOvfSet = lowerCarry & splitMode;
	assign anyOverflow = upperOvfSet | lowerOvfSet;

	// Bus handshakes
	assign writeFire = awHeld_r & wHeld_r & ~s_axi_bvalid;
	assign readFire  = s_axi_arvalid & s_axi_arready;
	assign readAddr  = s_axi_araddr[`AEC_ADDR_W-1:0];
	assign wrCtrl    = writeFire & (awAddr_r == `AEC_ADDR_CTRL_STATUS) & wStrb_r[0];
	assign wrConfig  = writeFire & (awAddr_r == `AEC_ADDR_CONFIG);
	assign wrMapped  = (awAddr_r == `AEC_ADDR_CTRL_STATUS) | (awAddr_r == `AEC_ADDR_CONFIG)
		| (awAddr_r == `AEC_ADDR_COUNT_HIGH) | (awAddr_r == `AEC_ADDR_COUNT_LOW);
	assign rdCtrl    = readFire & (readAddr == `AEC_ADDR_CTRL_STATUS);

	// Read multiplexer; counters are read-only
	// [RULE_11] upper byte readback
	// [RULE_12] lower byte readback
	always @* begin
		readData = 32'h0000_0000;
		readHit  = 1'b1;
		case (readAddr)
			`AEC_ADDR_CTRL_STATUS: readData[7:0] = ctrlStatus_r;
			`AEC_ADDR_COUNT_HIGH:  readData[7:0] = upperCount_r;
			`AEC_ADDR_COUNT_LOW:   readData[7:0] = lowerCount_r;
			`AEC_ADDR_CONFIG:      readData[`AEC_CFG_W-1:0] = config_r;
			default:               readHit = 1'b0;
		endcase
		if (s_axi_araddr[31:`AEC_ADDR_W] != 28'h000_0000) begin
			readHit = 1'b0;
		end
	end

	// Counter next values
	// [RULE_09] upper held cleared
	// [RULE_10] lower held cleared
	always @* begin
		lowerCount_nxt = lowerCount_r;
		upperCount_nxt = upperCount_r;
		if (!ctrlStatus_r[`AEC_CS_LOWER_REL]) begin
			lowerCount_nxt = `AEC_COUNT_ZERO;
		end else if (lowerTick) begin
			lowerCount_nxt = lowerCount_r + 8'h01;
		end
		if (!ctrlStatus_r[`AEC_CS_UPPER_REL]) begin
			upperCount_nxt = `AEC_COUNT_ZERO;
		end else if (upperTick) begin
			upperCount_nxt = upperCount_r + 8'h01;
		end
	end

	// Control/status next value with read-then-clear flags
	always @* begin
		ctrlStatus_nxt      = ctrlStatus_r;
		upperClearArmed_nxt = upperClearArmed_r;
		lowerClearArmed_nxt = lowerClearArmed_r;
		// Reading a flag as one arms its clear
		if (rdCtrl) begin
			upperClearArmed_nxt = upperClearArmed_r | ctrlStatus_r[`AEC_CS_UPPER_OVF];
			lowerClearArmed_nxt = lowerClearArmed_r | ctrlStatus_r[`AEC_CS_LOWER_OVF];
		end
		if (wrCtrl) begin
			// Plain bits, reserved bit kept as written
			// [RULE_15] reserved bit stored
			ctrlStatus_nxt[5:0] = wData_r[5:0];
			// [RULE_03] armed zero write clears
			// [RULE_04] ones are ignored
			if (!wData_r[`AEC_CS_UPPER_OVF] && upperClearArmed_r) begin
				ctrlStatus_nxt[`AEC_CS_UPPER_OVF] = 1'b0;
			end
			if (!wData_r[`AEC_CS_LOWER_OVF] && lowerClearArmed_r) begin
				ctrlStatus_nxt[`AEC_CS_LOWER_OVF] = 1'b0;
			end
			upperClearArmed_nxt = 1'b0;
			lowerClearArmed_nxt = 1'b0;
		end
		// [RULE_20] set wins over clear
		if (upperOvfSet) begin
			ctrlStatus_nxt[`AEC_CS_UPPER_OVF] = 1'b1;
		end
		if (lowerOvfSet) begin
			ctrlStatus_nxt[`AEC_CS_LOWER_OVF] = 1'b1;
		end
	end

	// Configuration next value, interrupt flag cleared by writing zero
	always @* begin
		config_nxt = config_r;
		if (wrConfig && wStrb_r[0]) begin
			config_nxt[7:0] = wData_r[7:0];
		end
		if (wrConfig && wStrb_r[1]) begin
			config_nxt[`AEC_CFG_PWM_GATE_EN] = wData_r[`AEC_CFG_PWM_GATE_EN];
			config_nxt[`AEC_CFG_IRQ_EN]      = wData_r[`AEC_CFG_IRQ_EN];
			if (!wData_r[`AEC_CFG_IRQ_FLAG]) begin
				config_nxt[`AEC_CFG_IRQ_FLAG] = 1'b0;
			end
		end
		// [RULE_18] overflow sets irq flag
		if (anyOverflow) begin
			config_nxt[`AEC_CFG_IRQ_FLAG] = 1'b1;
		end
	end

	// Register and counter update
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrlStatus_r      <= `AEC_CS_RESET;
			config_r          <= `AEC_CFG_RESET;
			upperCount_r      <= `AEC_COUNT_ZERO;
			lowerCount_r      <= `AEC_COUNT_ZERO;
			upperClearArmed_r <= 1'b0;
			lowerClearArmed_r <= 1'b0;
			overflowIrq_r     <= 1'b0;
		end else begin
			ctrlStatus_r      <= ctrlStatus_nxt;
			config_r          <= config_nxt;
			upperCount_r      <= upperCount_nxt;
			lowerCount_r      <= lowerCount_nxt;
			upperClearArmed_r <= upperClearArmed_nxt;
			lowerClearArmed_r <= lowerClearArmed_nxt;
			// [RULE_18] request when enabled
			overflowIrq_r     <= config_nxt[`AEC_CFG_IRQ_FLAG] & config_nxt[`AEC_CFG_IRQ_EN];
		end
	end

	// Write channel: address and data taken in either order
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			awHeld_r      <= 1'b0;
			wHeld_r       <= 1'b0;
			awAddr_r      <= {`AEC_ADDR_W{1'b0}};
			wData_r       <= 32'h0000_0000;
			wStrb_r       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `AEC_RESP_OKAY;
		end else begin
			s_axi_awready <= ~awHeld_r & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready  <= ~wHeld_r & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr[`AEC_ADDR_W-1:0];
				if (s_axi_awaddr[31:`AEC_ADDR_W] != 28'h000_0000) begin
					awAddr_r <= 4'h3; // Unaligned code, never mapped
				end
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (writeFire) begin
				awHeld_r     <= 1'b0;
				wHeld_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrMapped ? `AEC_RESP_OKAY : `AEC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel: one read under way at a time
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `AEC_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~readFire;
			if (readFire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= readData;
				s_axi_rresp  <= readHit ? `AEC_RESP_OKAY : `AEC_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // aec_event_counter
`default_nettype wire

// [aec_event_counter_checker.sv]
// Purpose: Port checks of the dual event counter
// Assumes: One ref_clk domain, reset_n active low
// Notes:   Bound to aec_event_counter below the module
`timescale 1ns/1ps
`default_nettype none
`include "aec_consts.vh"

module aec_checker (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        reset_n,
	// Write side
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	// Read side
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	// Interrupt
	input wire logic        overflowIrq_r
);
	logic wrTake;
	logic rdTake;

	// Both write channels taken together, or a read taken
	assign wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign rdTake = s_axi_arvalid && s_axi_arready;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	// Answer timing and release
	a_write_answer: assert property (wrTake |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	a_read_answer: assert property (rdTake |=> s_axi_rvalid)
		else $error("read answer late");
	a_bvalid_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid kept after accept");
	a_rvalid_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid kept after accept");
	// No new request taken while an answer is pending
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	// Unmapped addresses are answered with an error
	a_read_unmapped: assert property (rdTake && s_axi_araddr[31:4] != 28'h0
		|=> s_axi_rresp == `AEC_RESP_SLVERR) else $error("unmapped read not refused");
	a_write_unmapped: assert property (wrTake && s_axi_awaddr[31:4] != 28'h0
		|-> ##[1:2] (s_axi_bvalid && s_axi_bresp == `AEC_RESP_SLVERR))
		else $error("unmapped write not refused");
	// Counter registers accept writes without effect or error
	a_count_readonly: assert property (wrTake
		&& (s_axi_awaddr == 32'h4 || s_axi_awaddr == 32'h8)
		|-> ##[1:2] (s_axi_bvalid && s_axi_bresp == `AEC_RESP_OKAY))
		else $error("count write refused");
	a_data_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:11] == 21'h0)
		else $error("read data above field");

	// Main scenarios
	c_write: cover property (wrTake);
	c_read_error: cover property (rdTake && s_axi_araddr[31:4] != 28'h0);
	c_irq: cover property ($rose(overflowIrq_r));
endmodule // aec_checker

bind aec_event_counter aec_checker i_aec_checker (
	.ref_clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
	.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .overflowIrq_r
);
`default_nettype wire

// [aec_event_partner.sv]
// Purpose: Event pin source for the dual event counter
// Assumes: Pins sampled on ref_clk
// Notes:   Pins idle high; each event is one low pulse, a falling then a rising edge
`timescale 1ns/1ps
`default_nettype none

module aec_event_partner (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	// Commands from the bench
	input  wire logic       fireUpper,
	input  wire logic       fireLower,
	input  wire logic       slow,
	input  wire logic [7:0] pulseNum,
	// Pins and status
	output wire logic       upperEventPin,
	output wire logic       lowerEventPin,
	output wire logic       busy
);
	logic [7:0] left_r;
	logic [1:0] phase_r;
	logic       toUpper_r;
	logic       lowPhase;

	// Pulse train: low phase, then one high cycle per event
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			left_r    <= 8'h00;
			phase_r   <= 2'h0;
			toUpper_r <= 1'b0;
		end else if (left_r == 8'h00) begin
			phase_r <= 2'h0;
			if (fireUpper || fireLower) begin
				left_r    <= pulseNum;
				toUpper_r <= fireUpper;
			end
		end else if (phase_r == {1'b0, slow} + 2'h1) begin
			phase_r <= 2'h0;
			left_r  <= left_r - 8'h01;
		end else begin
			phase_r <= phase_r + 2'h1;
		end
	end

	// Pins low for one cycle, or two when slow
	assign busy          = (left_r != 8'h00);
	assign lowPhase      = busy && (phase_r == 2'h0 || (slow && phase_r == 2'h1));
	assign upperEventPin = !(lowPhase && toUpper_r);
	assign lowerEventPin = !(lowPhase && !toUpper_r);
endmodule // aec_event_partner
`default_nettype wire

// [aec_prescaler.v]
// Purpose: Divided system clock ticks for the event counters
// Assumes: One ref_clk domain, asynchronous active-low reset
// Notes:   Each tick is a one-cycle pulse at 1/2, 1/4 or 1/8 of the clock rate
`timescale 1ns/1ps
`default_nettype none
`include "aec_consts.vh"

module aec_prescaler (
	// Clock and reset
	input  wire       ref_clk,
	input  wire       reset_n,
	// Tick pulses
	output reg        tickDiv2_r,
	output reg        tickDiv4_r,
	output reg        tickDiv8_r
);

	reg  [2:0] divCount_r;
	wire [2:0] divCount_nxt;

	// Free-running divider
	assign divCount_nxt = divCount_r + 3'h1;

	// Divider and tick pulses
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			divCount_r <= 3'h0;
			tickDiv2_r <= 1'b0;
			tickDiv4_r <= 1'b0;
			tickDiv8_r <= 1'b0;
		end else begin
			divCount_r <= divCount_nxt;
			tickDiv2_r <= (divCount_r[0] == 1'b1);
			tickDiv4_r <= (divCount_r[1:0] == 2'h3);
			tickDiv8_r <= (divCount_r == 3'h7);
		end
	end

endmodule // aec_prescaler
`default_nettype wire

// [aec_source_select.v]
// Purpose: Edge sensing of one event pin and choice of the count source
// Assumes: Pin is synchronous to ref_clk
// Notes:   Edge code 11 senses nothing; output tick is combinational
`timescale 1ns/1ps
`default_nettype none
`include "aec_consts.vh"

module aec_source_select (
	// Clock and reset
	input  wire       ref_clk,
	input  wire       reset_n,
	// Event pin and selects
	input  wire       eventPin,
	input  wire [1:0] edgeSel,
	input  wire [1:0] clockSel,
	// Prescaled ticks
	input  wire       tickDiv2,
	input  wire       tickDiv4,
	input  wire       tickDiv8,
	// Selected source
	output reg        sourceTick
);

	reg pinPrev_r;
	reg pinEdge;

	// Previous pin sample
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pinPrev_r <= 1'b1;
		end else begin
			pinPrev_r <= eventPin;
		end
	end

	// Edge sensing and source multiplexer
	always @* begin
		case (edgeSel)
			`AEC_EDGE_FALL: pinEdge = pinPrev_r & ~eventPin;
			`AEC_EDGE_RISE: pinEdge = ~pinPrev_r & eventPin;
			`AEC_EDGE_BOTH: pinEdge = pinPrev_r ^ eventPin;
			default:        pinEdge = 1'b0;
		endcase
		case (clockSel)
			`AEC_CLK_PIN:  sourceTick = pinEdge;
			`AEC_CLK_DIV2: sourceTick = tickDiv2;
			`AEC_CLK_DIV4: sourceTick = tickDiv4;
			default:       sourceTick = tickDiv8;
		endcase
	end

endmodule // aec_source_select
`default_nettype wire

// [aec_testbench.sv]
// Purpose: Self-checking bench of the dual event counter
// Assumes: 100 MHz ref_clk, AXI4-Lite master tasks
// Notes:   Gate windows give exact tick counts
`timescale 1ns/1ps
`default_nettype none
`include "aec_consts.vh"

module testbench;
	localparam logic [31:0] A_CS  = {28'h0, `AEC_ADDR_CTRL_STATUS};
	localparam logic [31:0] A_HI  = {28'h0, `AEC_ADDR_COUNT_HIGH};
	localparam logic [31:0] A_LO  = {28'h0, `AEC_ADDR_COUNT_LOW};
	localparam logic [31:0] A_CFG = {28'h0, `AEC_ADDR_CONFIG};
	// Bench driven signals
	logic ref_clk = 1'b0, reset_n = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic externalCountGate = 1'b0, pwmCountGate = 1'b0;
	logic fireUpper = 1'b0, fireLower = 1'b0, slow = 1'b0;
	logic [7:0] pulseNum = 8'h00;
	// Design and partner outputs
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic upperEventPin, lowerEventPin, busy, overflowIrq_r;
	int badCount = 0, checkCount = 0;

	// Clock
	always #5 ref_clk = ~ref_clk;

	aec_event_counter i_aec_event_counter (
		.ref_clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .upperEventPin, .lowerEventPin, .externalCountGate,
		.pwmCountGate, .overflowIrq_r
	);
	aec_event_partner i_aec_event_partner (
		.ref_clk, .reset_n, .fireUpper, .fireLower, .slow, .pulseNum,
		.upperEventPin, .lowerEventPin, .busy
	);

	// Compare one value and tally it
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checkCount++;
		if (g !== e) begin
			badCount++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Write with both channels offered together
	task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w;
		int n;
		aw = 1'b0;
		w = 1'b0;
		n = 0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w) && n < 64) begin
			@(posedge ref_clk);
			n++;
			if (!aw && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge ref_clk);
			n++;
		end while (!s_axi_bvalid && n < 64);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 64) badCount++;
	endtask

	// Write expecting an OKAY answer
	task automatic wo(input logic [31:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk("bresp", 32'h0, {30'h0, r});
	endtask

	// Read one register
	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!s_axi_arready && n < 64);
		s_axi_arvalid <= 1'b0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!s_axi_rvalid && n < 64);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 64) badCount++;
	endtask

	// Read and compare
	task automatic rdc(input logic [31:0] a, input logic [31:0] e, input string nm);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(nm, e, d);
	endtask

	// Hold one count gate high for a fixed number of edges
	task automatic gate(input int cyc, input logic pwm);
		@(posedge ref_clk);
		if (pwm) pwmCountGate <= 1'b1;
		else externalCountGate <= 1'b1;
		repeat (cyc) @(posedge ref_clk);
		externalCountGate <= 1'b0;
		pwmCountGate <= 1'b0;
	endtask

	// Ask the partner for a burst of pin events
	task automatic pins(input logic up, input logic sl, input logic [7:0] num);
		int n;
		n = 0;
		@(posedge ref_clk);
		slow <= sl;
		pulseNum <= num;
		fireUpper <= up;
		fireLower <= !up;
		@(posedge ref_clk);
		fireUpper <= 1'b0;
		fireLower <= 1'b0;
		do begin
			@(posedge ref_clk);
			n++;
		end while ((busy || n < 2) && n < 2000);
		if (n >= 2000) badCount++;
	endtask

	// Print counts and the verdict, then stop
	task automatic wrapUp;
		$display("checks %0d errors %0d", checkCount, badCount);
		if (badCount == 0 && checkCount > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// Cut a hang short
	initial begin
		#200000;
		badCount++;
		wrapUp;
	end

	// Test sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rdc(A_CS, 32'h0, "ctrl reset");
		rdc(A_HI, 32'h0, "high reset");
		rdc(A_LO, 32'h0, "low reset");
		rdc(A_CFG, 32'h0, "config reset");
		wr(32'h100, 32'hFF, r);
		chk("unmapped bresp", 32'h2, {30'h0, r});
		rd(32'h100, d, r);
		chk("unmapped rresp", 32'h2, {30'h0, r});
		wo(A_HI, 32'hFF);
		rdc(A_HI, 32'h0, "high after write");
		wo(A_CS, 32'h0F);
		externalCountGate <= 1'b1;
		pins(1'b0, 1'b0, 8'h05);
		rdc(A_LO, 32'h5, "low pin");
		rdc(A_HI, 32'h0, "high pin");
		wo(A_CS, 32'h1F);
		pins(1'b1, 1'b1, 8'h03);
		rdc(A_HI, 32'h3, "high pin");
		rdc(A_LO, 32'h5, "low kept");
		externalCountGate <= 1'b0;
		for (int c = 1; c < 4; c++) begin
			wo(A_CS, 32'h10);
			wo(A_CFG, (c << 6) | (c << 4));
			wo(A_CS, 32'h1F);
			gate(64, 1'b0);
			rdc(A_HI, 64 >> c, "high div");
			rdc(A_LO, 64 >> c, "low div");
		end
		wo(A_CS, 32'h13);
		gate(64, 1'b0);
		rdc(A_HI, 32'h8, "high held");
		rdc(A_LO, 32'h8, "low held");
		wo(A_CS, 32'h1C);
		gate(64, 1'b0);
		rdc(A_HI, 32'h0, "high cleared");
		rdc(A_LO, 32'h0, "low cleared");
		wo(A_CFG, 32'h150);
		wo(A_CS, 32'h1F);
		gate(64, 1'b0);
		rdc(A_LO, 32'h0, "low ext ignored");
		gate(64, 1'b1);
		rdc(A_LO, 32'h20, "low pwm gate");
		wo(A_CFG, 32'h10);
		wo(A_CS, 32'h0C);
		wo(A_CS, 32'h0F);
		gate(512, 1'b0);
		rdc(A_LO, 32'h0, "low wrap");
		rdc(A_HI, 32'h1, "high carry");
		rdc(A_CS, 32'h0F, "no lower flag");
		wo(A_CS, 32'h10);
		wo(A_CFG, 32'h450);
		wo(A_CS, 32'h1F);
		gate(512, 1'b0);
		rdc(A_HI, 32'h0, "high wrap");
		rdc(A_CFG, 32'h650, "irq flag");
		chk("irq", 32'h1, {31'h0, overflowIrq_r});
		wo(A_CS, 32'h1F);
		rdc(A_CS, 32'hDF, "flags unread");
		wo(A_CS, 32'hDF);
		rdc(A_CS, 32'hDF, "flags one");
		wo(A_CS, 32'h1F);
		rdc(A_CS, 32'h1F, "flags cleared");
		wo(A_CFG, 32'h450);
		chk("irq", 32'h0, {31'h0, overflowIrq_r});
		// Lower pin with rising and then both edge sensing
		wo(A_CFG, 32'h01);
		externalCountGate <= 1'b1;
		pins(1'b0, 1'b0, 8'h03);
		rdc(A_LO, 32'h3, "low rise");
		wo(A_CFG, 32'h02);
		pins(1'b0, 1'b1, 8'h02);
		rdc(A_LO, 32'h7, "low both");
		externalCountGate <= 1'b0;
		wrapUp;
	end
endmodule // testbench
`default_nettype wire
